// [rtl/reset_self_test.sv]
// Reset self-test sequencer driving the status lights and host ready flag.
`timescale 1ns/1ns
`default_nettype none
module reset_self_test #(
  parameter int unsigned WALK_CYC  = self_test_pkg::WALK_STEP_CYC,
  parameter int unsigned PAUSE_CYC = self_test_pkg::PAUSE_CYC
) (
  // Clock and reset.
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  // Pins from the host card cage and the service switch.
  input  wire logic                      host_reset_n,
  input  wire logic                      configure_req,
  input  wire logic                      service_test_switch,
  // Step checker results.
  input  wire logic                      check_done,
  input  wire logic                      check_fail,
  // Host-requested test progress.
  input  wire logic                      phase_start,
  input  wire logic [2:0]                phase_sel,
  input  wire logic                      subtest_next,
  input  wire logic                      subtest_err,
  // Status lights and step checker request.
  output self_test_pkg::lights_s         lights,
  output self_test_pkg::check_req_s      check_req,
  // Host status.
  output logic                           board_ready,
  output logic                           host_comm_en,
  output logic                           subtest_err_seen,
  // Processor data bus jam.
  output logic [7:0]                     cpu_data_jam,
  output logic                           cpu_data_oe_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]                 hrst_sync_r;
  logic [1:0]                 hrst_sync_nxt;
  logic [2:0]                 cfg_sync_r;
  logic [2:0]                 cfg_sync_nxt;
  logic [1:0]                 sw_sync_r;
  logic [1:0]                 sw_sync_nxt;
  logic                       restart;
  self_test_pkg::state_e      state_r;
  self_test_pkg::state_e      state_nxt;
  logic [2:0]                 step_r;
  logic [2:0]                 step_nxt;
  logic [2:0]                 walk_r;
  logic [2:0]                 walk_nxt;
  logic [31:0]                cnt_r;
  logic [31:0]                cnt_nxt;
  logic [4:0]                 hidx_r;
  logic [4:0]                 hidx_nxt;
  logic [4:0]                 hlast_r;
  logic [4:0]                 hlast_nxt;
  self_test_pkg::lights_s     lights_r;
  self_test_pkg::lights_s     lights_nxt;
  self_test_pkg::check_req_s  chk_r;
  self_test_pkg::check_req_s  chk_nxt;
  logic                       ready_r;
  logic                       ready_nxt;
  logic                       comm_r;
  logic                       comm_nxt;
  logic                       err_r;
  logic                       err_nxt;
  logic                       oe_n_r;
  logic                       oe_n_nxt;
  logic [7:0]                 jam_r;
  logic [7:0]                 jam_nxt;

  // Light pattern for a self-test step, lead light off only on step zero.
  function automatic self_test_pkg::lights_s step_lights(input logic [2:0] s);
    step_lights.lead = (s != self_test_pkg::STEP_REGS);
    step_lights.code = self_test_pkg::SELF_CODE[s];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Each pin passes two flops; the third configure flop only feeds edge detect.
  always_comb begin
    hrst_sync_nxt = {hrst_sync_r[0], host_reset_n};
    cfg_sync_nxt  = {cfg_sync_r[1:0], configure_req};
    sw_sync_nxt   = {sw_sync_r[0], service_test_switch};
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hrst_sync_r <= 2'h3;
      cfg_sync_r  <= 3'h0;
      sw_sync_r   <= 2'h0;
    end else begin
      hrst_sync_r <= hrst_sync_nxt;
      cfg_sync_r  <= cfg_sync_nxt;
      sw_sync_r   <= sw_sync_nxt;
    end
  end

  // A host reset, a new configuration or the jam switch restarts the test.
  assign restart = !hrst_sync_r[1]
                   || (cfg_sync_r[1] && !cfg_sync_r[2])
                   || sw_sync_r[1];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next-state logic for the self-test steps and the host test phases.
  always_comb begin
    state_nxt  = state_r;
    step_nxt   = step_r;
    walk_nxt   = walk_r;
    cnt_nxt    = cnt_r;
    hidx_nxt   = hidx_r;
    hlast_nxt  = hlast_r;
    lights_nxt = lights_r;
    chk_nxt    = '{start: 1'b0, step: chk_r.step};
    ready_nxt  = ready_r;
    comm_nxt   = comm_r;
    err_nxt    = err_r;
    if (restart) begin
      state_nxt = self_test_pkg::ST_START;
      ready_nxt = 1'b0;
      comm_nxt  = 1'b1;
    end else begin
      unique case (state_r)
        self_test_pkg::ST_START: begin
          step_nxt   = self_test_pkg::STEP_REGS;
          lights_nxt = step_lights(self_test_pkg::STEP_REGS);
          chk_nxt    = '{start: 1'b1, step: self_test_pkg::STEP_REGS};
          ready_nxt  = 1'b0;
          comm_nxt   = 1'b1;
          state_nxt  = self_test_pkg::ST_CHECK;
        end
        self_test_pkg::ST_CHECK: begin
          if (check_done) begin
            cnt_nxt = 32'h0;
            if (check_fail) begin
              comm_nxt  = 1'b0;
              state_nxt = self_test_pkg::ST_HALT;
            end else if (step_r == self_test_pkg::STEP_RAM_ADDR) begin
              step_nxt   = self_test_pkg::STEP_PASSED;
              lights_nxt = step_lights(self_test_pkg::STEP_PASSED);
              state_nxt  = self_test_pkg::ST_PAUSE;
            end else if (step_r == self_test_pkg::STEP_REGS) begin
              step_nxt   = 3'h1;
              walk_nxt   = 3'h0;
              lights_nxt = step_lights(3'h1);
              state_nxt  = self_test_pkg::ST_WALK;
            end else begin
              // Steps 3 to 5 are data-only checks, step 6 the address check.
              step_nxt   = 3'(step_r + 3'h1);
              lights_nxt = step_lights(3'(step_r + 3'h1));
              chk_nxt    = '{start: 1'b1, step: 3'(step_r + 3'h1)};
            end
          end
        end
        self_test_pkg::ST_WALK: begin
          cnt_nxt = 32'(cnt_r + 32'h1);
          if (cnt_r == 32'(WALK_CYC - 1)) begin
            cnt_nxt = 32'h0;
            if (walk_r == self_test_pkg::WALK_LAST) begin
              step_nxt   = self_test_pkg::STEP_ROM;
              lights_nxt = step_lights(self_test_pkg::STEP_ROM);
              chk_nxt    = '{start: 1'b1, step: self_test_pkg::STEP_ROM};
              state_nxt  = self_test_pkg::ST_CHECK;
            end else begin
              // After the all-on interval a single light walks across.
              walk_nxt        = 3'(walk_r + 3'h1);
              lights_nxt.code = 7'(7'h01 << walk_r);
            end
          end
        end
        self_test_pkg::ST_PAUSE: begin
          // Lights stay static so the final code can be read.
          cnt_nxt = 32'(cnt_r + 32'h1);
          if (cnt_r == 32'(PAUSE_CYC - 1)) begin
            ready_nxt = 1'b1;
            state_nxt = self_test_pkg::ST_HOST;
          end
        end
        self_test_pkg::ST_HOST: begin
          if (phase_start && (phase_sel < self_test_pkg::NUM_PHASES)) begin
            hidx_nxt   = self_test_pkg::PHASE_FIRST[phase_sel];
            hlast_nxt  = self_test_pkg::PHASE_LAST[phase_sel];
            lights_nxt = '{lead: 1'b1,
              code: self_test_pkg::HOST_CODE[self_test_pkg::PHASE_FIRST[phase_sel]]};
            err_nxt    = 1'b0;
          end else if (subtest_next && (hidx_r != hlast_r)) begin
            hidx_nxt        = 5'(hidx_r + 5'h01);
            lights_nxt.code = self_test_pkg::HOST_CODE[5'(hidx_r + 5'h01)];
          end
          // Subtest errors are only remembered; the sequence keeps going.
          if (subtest_err) begin
            err_nxt = 1'b1;
          end
        end
        self_test_pkg::ST_HALT: begin
          comm_nxt = 1'b0;
        end
        default: begin
          state_nxt = self_test_pkg::ST_START;
        end
      endcase
    end
  end

  // Sequencer registers.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r  <= self_test_pkg::ST_START;
      step_r   <= 3'h0;
      walk_r   <= 3'h0;
      cnt_r    <= 32'h0;
      hidx_r   <= 5'h00;
      hlast_r  <= 5'h00;
      lights_r <= '{lead: 1'b0, code: 7'h00};
      chk_r    <= '{start: 1'b0, step: 3'h0};
      ready_r  <= 1'b0;
      comm_r   <= 1'b0;
      err_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      step_r   <= step_nxt;
      walk_r   <= walk_nxt;
      cnt_r    <= cnt_nxt;
      hidx_r   <= hidx_nxt;
      hlast_r  <= hlast_nxt;
      lights_r <= lights_nxt;
      chk_r    <= chk_nxt;
      ready_r  <= ready_nxt;
      comm_r   <= comm_nxt;
      err_r    <= err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Service jam of the processor data bus
  // ----------------------------------------------------------------
  // Enable is low and the fixed opcode is presented while the switch is in test.
  always_comb begin
    oe_n_nxt = !sw_sync_r[1];
    jam_nxt  = sw_sync_r[1] ? self_test_pkg::JAM_OPCODE : 8'h00;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      oe_n_r <= 1'b1;
      jam_r  <= 8'h00;
    end else begin
      oe_n_r <= oe_n_nxt;
      jam_r  <= jam_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Code bits 6:4 feed lights a-c and bits 3:0 feed lights d-g.
  assign lights           = lights_r;
  assign check_req        = chk_r;
  assign board_ready      = ready_r;
  assign host_comm_en     = comm_r;
  assign subtest_err_seen = err_r;
  assign cpu_data_jam     = jam_r;
  assign cpu_data_oe_n    = oe_n_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  AST_HALT_FREEZE: assert property (
    (state_r == self_test_pkg::ST_HALT) && !restart |=> $stable(lights_r) && !comm_r)
    else $error("Lights or host link changed while halted.");

  AST_LEAD_OFF_FIRST: assert property (
    (state_r == self_test_pkg::ST_CHECK) && (step_r == 3'h0) |-> !lights_r.lead)
    else $error("Lead light lit during register test.");

  AST_LEAD_ON_LATER: assert property (
    (state_r inside {self_test_pkg::ST_WALK, self_test_pkg::ST_PAUSE,
                     self_test_pkg::ST_HOST}) |-> lights_r.lead)
    else $error("Lead light dark after first step.");

  AST_PAUSE_CODE: assert property (
    (state_r == self_test_pkg::ST_PAUSE) && !restart |=>
      (lights_r.code == 7'h11) && $stable(lights_r))
    else $error("Pass pause pattern not held at 11.");

  AST_RAM_ADDR_CODE: assert property (
    chk_r.start && (chk_r.step == 3'h6) |-> (lights_r.code == 7'h06))
    else $error("Address test not shown as 06.");

  AST_ROM_AFTER_WALK: assert property (
    chk_r.start && (chk_r.step == 3'h2) |->
      (lights_r.code == 7'h01) && ($past(state_r) == self_test_pkg::ST_WALK))
    else $error("Checksum step not entered from walk with code 01.");

  AST_READY_AFTER_PASS: assert property (
    $rose(ready_r) |-> ($past(state_r) == self_test_pkg::ST_PAUSE) &&
      (lights_r.code == 7'h11))
    else $error("Ready raised without passing all steps.");

  AST_NO_HALT_HOST: assert property (
    (state_r == self_test_pkg::ST_HOST) && subtest_err && !restart |=>
      (state_r == self_test_pkg::ST_HOST) && err_r && ready_r)
    else $error("Host test error stopped the sequence.");

  AST_RESTART: assert property (
    restart |=> (state_r == self_test_pkg::ST_START) && !ready_r ##1
      ($past(restart) || chk_r.start))
    else $error("Restart did not rerun the self-test.");

  AST_JAM: assert property (
    sw_sync_r[1] |=> !cpu_data_oe_n && (cpu_data_jam == 8'h5F) && !ready_r)
    else $error("Service switch did not jam the opcode.");

endmodule
`default_nettype wire

// [rtl/self_test_pkg.sv]
// Constants, tables and carriers for the board reset self-test sequencer.
// What this block does
// - Reset starts self-test; no results returned.
// - Self-test also reruns on every configure.
// - Eight ordered steps; lights updated per step.
// - Failure freezes lights and stops host talk.
// - Pause holds pass lights steady before host ready.
// - Lead light on except register test step.
// - Step codes 00,7F,01,03-05, pass 11.
// - Program RAM address test shows code 06.
// - Program RAM address+data; others data only.
// - All passed: signal host ready for data.
// - Host tests update lights, never halt.
// - Interface phase shows codes 10 to 15.
// - Acquisition phase shows 20-23, 30, 31, 33, 34 codes.
// - Counter phase shows codes 40 to 43.
// - Statistics phase shows codes 50 to 55.
// - Inter-module bus phase shows 60 to 64.
// - Test switch jams fixed opcode onto bus.
package self_test_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 20_000_000;
  localparam int WALK_STEP_US  = 50_000;
  localparam int PAUSE_US      = 500_000;
  localparam int WALK_STEP_CYC = WALK_STEP_US * (CLK_HZ / 1_000_000);
  localparam int PAUSE_CYC     = PAUSE_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // Self-test steps and light codes
  // ----------------------------------------------------------------
  localparam logic [2:0] STEP_REGS     = 3'h0;
  localparam logic [2:0] STEP_ROM      = 3'h2;
  localparam logic [2:0] STEP_RAM_ADDR = 3'h6;
  localparam logic [2:0] STEP_PASSED   = 3'h7;
  localparam logic [2:0] WALK_LAST     = 3'h7;
  localparam logic [6:0] ALL_LIGHTS    = 7'h7F;
  localparam logic [6:0] SELF_CODE [8] = '{7'h00, 7'h7F, 7'h01, 7'h03,
                                           7'h04, 7'h05, 7'h06, 7'h11};

  // ----------------------------------------------------------------
  // Host-requested test phases, flattened code list
  // ----------------------------------------------------------------
  localparam logic [2:0] NUM_PHASES    = 3'h5;
  localparam logic [6:0] HOST_CODE [29] = '{
    7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15,
    7'h20, 7'h21, 7'h22, 7'h23, 7'h30, 7'h31, 7'h33, 7'h34,
    7'h40, 7'h41, 7'h42, 7'h43,
    7'h50, 7'h51, 7'h52, 7'h53, 7'h54, 7'h55,
    7'h60, 7'h61, 7'h62, 7'h63, 7'h64};
  localparam logic [4:0] PHASE_FIRST [5] = '{5'h00, 5'h06, 5'h0E, 5'h12, 5'h18};
  localparam logic [4:0] PHASE_LAST  [5] = '{5'h05, 5'h0D, 5'h11, 5'h17, 5'h1C};

  // ----------------------------------------------------------------
  // Service jam opcode
  // ----------------------------------------------------------------
  localparam logic [7:0] JAM_OPCODE = 8'h5F;

  // ----------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       lead;
    logic [6:0] code;
  } lights_s;

  typedef struct packed {
    logic       start;
    logic [2:0] step;
  } check_req_s;

  typedef enum logic [2:0] {
    ST_START, ST_CHECK, ST_WALK, ST_PAUSE, ST_HOST, ST_HALT
  } state_e;

endpackage

// [verification/self_test_host_model.sv]
// Step checker and host station model facing the reset self-test sequencer.
`timescale 1ns/1ns
`default_nettype none
module self_test_host_model #(
  parameter int unsigned RESET_PERIOD = 400
) (
  // Clock and reset.
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  // Scenario controls.
  input  wire logic                      periodic_en,
  input  wire logic                      fail_en,
  input  wire logic [2:0]                fail_step,
  input  wire logic [3:0]                answer_dly,
  // Sequencer side.
  input  wire self_test_pkg::check_req_s check_req,
  output logic                           check_done,
  output logic                           check_fail,
  output logic                           host_reset_n
);
  logic [3:0]  cnt_r;
  logic [15:0] period_r;

  // Answers each step request after answer_dly cycles; fail toggles as noise off the pulse.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_r      <= 4'h0;
      check_done <= 1'b0;
      check_fail <= 1'b0;
    end else begin
      check_done <= (cnt_r == 4'h1);
      check_fail <= (cnt_r == 4'h1) ? (fail_en && check_req.step == fail_step) : ~check_fail;
      if (check_req.start) begin
        cnt_r <= answer_dly;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end

  // Pulses the board reset low for three cycles once a period and expects nothing back.
  always_ff @(posedge core_clk) begin
    if (!rst_n || !periodic_en) begin
      period_r     <= 16'h0;
      host_reset_n <= 1'b1;
    end else begin
      period_r     <= (32'(period_r) == RESET_PERIOD - 1) ? 16'h0 : period_r + 16'h1;
      host_reset_n <= (period_r >= 16'h3);
    end
  end
endmodule
`default_nettype wire

// [verification/reset_self_test_bench.sv]
// Self-checking bench for the reset self-test sequencer.
`timescale 1ns/1ns
`default_nettype none
module reset_self_test_bench;
  localparam int PAUSE = 8;
  logic                      core_clk, rst_n, configure_req, service_test_switch;
  logic                      phase_start, subtest_next, subtest_err;
  logic [2:0]                phase_sel, fail_step;
  logic                      periodic_en, fail_en, host_reset_n, check_done, check_fail;
  logic [3:0]                answer_dly;
  self_test_pkg::lights_s    lights;
  self_test_pkg::check_req_s check_req;
  logic                      board_ready, host_comm_en, subtest_err_seen, cpu_data_oe_n;
  logic [7:0]                cpu_data_jam;
  int                        num_errors, checks, cycles;

  reset_self_test #(.WALK_CYC(4), .PAUSE_CYC(PAUSE)) reset_self_test_inst (
    .core_clk(core_clk), .rst_n(rst_n), .host_reset_n(host_reset_n),
    .configure_req(configure_req), .service_test_switch(service_test_switch),
    .check_done(check_done), .check_fail(check_fail), .phase_start(phase_start),
    .phase_sel(phase_sel), .subtest_next(subtest_next), .subtest_err(subtest_err),
    .lights(lights), .check_req(check_req), .board_ready(board_ready),
    .host_comm_en(host_comm_en), .subtest_err_seen(subtest_err_seen),
    .cpu_data_jam(cpu_data_jam), .cpu_data_oe_n(cpu_data_oe_n));

  self_test_host_model self_test_host_model_inst (
    .core_clk(core_clk), .rst_n(rst_n), .periodic_en(periodic_en), .fail_en(fail_en),
    .fail_step(fail_step), .answer_dly(answer_dly), .check_req(check_req),
    .check_done(check_done), .check_fail(check_fail), .host_reset_n(host_reset_n));

  // Free-running clock of 50 ns period.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Cuts a hang short and goes to the closing report.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("unexpected timeout expected finish seen hang");
      complete_run;
    end
  end

  // Drives and samples a fixed delay after each rising edge.
  task automatic tick;
    @(posedge core_clk);
    #5;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Waits for a step request and checks its step and light pattern.
  task automatic wait_start(input logic [2:0] st, input logic [7:0] lt);
    int n;
    n = 0;
    while (check_req.start !== 1'b1 && n < 500) begin
      tick;
      n++;
    end
    check("step", 8'(check_req.step), 8'(st));
    check("step lights", lights, lt);
    tick;
  endtask

  // Walks the self-test steps from the register test up to step index last.
  task automatic run_steps(input int last);
    logic [2:0] st [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    logic [7:0] lt [6] = '{8'h00, 8'h81, 8'h83, 8'h84, 8'h85, 8'h86};
    int i, n;
    for (i = 0; i <= last; i++) begin
      wait_start(st[i], lt[i]);
      n = 0;
      while (i == 0 && lights.code !== 7'h7F && n < 20) begin
        tick;
        n++;
      end
      if (i == 0) check("walk lights", lights, 8'hFF);
      while (i == 0 && lights.code === 7'h7F && n < 40) begin
        tick;
        n++;
      end
      if (i == 0) check("walk first light", lights, 8'h81);
    end
  endtask

  // Full pass: all steps, steady pause code, then ready for the host.
  task automatic t_pass(input string name);
    int n;
    logic moved;
    run_steps(5);
    n = 0;
    while (lights !== 8'h91 && n < 20) begin
      tick;
      n++;
    end
    check("pass lights", lights, 8'h91);
    n = 0;
    moved = 1'b0;
    while (board_ready !== 1'b1 && n < PAUSE + 10) begin
      if (lights !== 8'h91) moved = 1'b1;
      tick;
      n++;
    end
    check("pause steady", 8'(moved), 8'h00);
    check("pause length", 8'(n >= PAUSE - 1 && n <= PAUSE + 1), 8'h01);
    check("ready", 8'(board_ready), 8'h01);
    $display("test %s done", name);
  endtask

  // Every host phase, stepping past the last subtest and raising a subtest error.
  task automatic t_host;
    logic [6:0] first [5] = '{7'h10, 7'h20, 7'h40, 7'h50, 7'h60};
    logic [6:0] last [5] = '{7'h15, 7'h34, 7'h43, 7'h55, 7'h64};
    int cnt [5] = '{6, 8, 4, 6, 5};
    int p;
    for (p = 0; p < 5; p++) begin
      phase_sel = 3'(p);
      phase_start = 1'b1;
      tick;
      phase_start = 1'b0;
      tick;
      check("phase first", 8'(lights.code), 8'(first[p]));
      check("err clear", 8'(subtest_err_seen), 8'h00);
      subtest_next = 1'b1;
      repeat (cnt[p]) tick;
      subtest_next = 1'b0;
      subtest_err = 1'b1;
      tick;
      subtest_err = 1'b0;
      tick;
      check("phase last", 8'(lights.code), 8'(last[p]));
      check("err seen", 8'(subtest_err_seen), 8'h01);
      check("no halt", 8'(host_comm_en & board_ready), 8'h01);
    end
    phase_sel = 3'h5;
    phase_start = 1'b1;
    tick;
    phase_start = 1'b0;
    tick;
    check("bad phase", 8'(lights.code), 8'h64);
    $display("test host phases done");
  endtask

  // Failing RAM step freezes the lights until the next periodic host reset.
  task automatic t_fail;
    int n;
    logic moved;
    fail_step = 3'h4;
    fail_en = 1'b1;
    periodic_en = 1'b1;
    run_steps(3);
    n = 0;
    while (host_comm_en !== 1'b0 && n < 20) begin
      tick;
      n++;
    end
    check("halt comm", 8'(host_comm_en), 8'h00);
    moved = 1'b0;
    repeat (50) begin
      if (lights !== 8'h84 || board_ready !== 1'b0) moved = 1'b1;
      tick;
    end
    check("halt frozen", 8'(moved), 8'h00);
    fail_en = 1'b0;
    wait_start(3'h0, 8'h00);
    periodic_en = 1'b0;
    $display("test fail halt done");
  endtask

  // Configure pulse restarts the self-test, drops ready and reruns a full pass.
  task automatic t_config(input string name);
    configure_req = 1'b1;
    repeat (3) tick;
    configure_req = 1'b0;
    check("config restart", 8'(board_ready), 8'h00);
    t_pass(name);
  endtask

  // Service switch jams the opcode and holds the sequencer in restart.
  task automatic t_jam;
    service_test_switch = 1'b1;
    repeat (5) tick;
    check("jam on", 8'(cpu_data_oe_n), 8'h00);
    check("jam code", cpu_data_jam, 8'h5F);
    check("jam restart", 8'(board_ready), 8'h00);
    service_test_switch = 1'b0;
    repeat (5) tick;
    check("jam off", 8'(cpu_data_oe_n), 8'h01);
    check("jam released", cpu_data_jam, 8'h00);
    $display("test service jam done");
  endtask

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    configure_req = 1'b0;
    service_test_switch = 1'b0;
    phase_start = 1'b0;
    phase_sel = 3'h0;
    subtest_next = 1'b0;
    subtest_err = 1'b0;
    periodic_en = 1'b0;
    fail_en = 1'b0;
    fail_step = 3'h0;
    answer_dly = 4'h2;
    repeat (4) tick;
    check("reset lights", lights, 8'h00);
    check("reset ready", 8'(board_ready), 8'h00);
    check("reset jam", 8'(cpu_data_oe_n), 8'h01);
    rst_n = 1'b1;
    t_pass("first pass");
    t_host;
    t_config("configure pass");
    t_fail;
    answer_dly = 4'h5;
    t_config("slow pass");
    t_jam;
    complete_run;
  end
endmodule
`default_nettype wire
